// [shared/mpcp_defs.vh]
/*
 Constants for the master interrupt controller command port: port addresses, control-word field positions, command codes and reset values.
 Assumes it is included by bare name from two of the three design files; the bench files do not include it.
*/
`ifndef MPCP_DEFS_VH
`define MPCP_DEFS_VH

// ----------------------------------------
// Port addresses
// ----------------------------------------
`define MPCP_PORT_LOW 8'h20
`define MPCP_PORT_HIGH 8'h21

// ----------------------------------------
// Lower-port write decode, plus the upper-port second-word vector base field
// ----------------------------------------
`define MPCP_SEL_ICW1_BIT 4
`define MPCP_SEL_OCW3_BIT 3
`define MPCP_SINGLE_CONTROLLER_BIT_BIT 1
`define MPCP_IC4_BIT 0
`define MPCP_CMD_HI 7
`define MPCP_CMD_LO 5
`define MPCP_LVL_HI 2
`define MPCP_LVL_LO 0
`define MPCP_SMM_HI 6
`define MPCP_SMM_LO 5
`define MPCP_POLL_BIT 2
`define MPCP_RSEL_HI 1
`define MPCP_RSEL_LO 0
`define MPCP_VBASE_HI 7
`define MPCP_VBASE_LO 3

// ----------------------------------------
// Priority/EOI command codes
// ----------------------------------------
`define MPCP_CMD_ROT_AEOI_CLR 3'h0
`define MPCP_CMD_NS_EOI 3'h1
`define MPCP_CMD_NOP 3'h2
`define MPCP_CMD_SP_EOI 3'h3
`define MPCP_CMD_ROT_AEOI_SET 3'h4
`define MPCP_CMD_ROT_NS_EOI 3'h5
`define MPCP_CMD_SET_PRIO 3'h6
`define MPCP_CMD_ROT_SP_EOI 3'h7

// ----------------------------------------
// Mask/poll/status field codes
// ----------------------------------------
`define MPCP_SMM_CLR 2'h2
`define MPCP_SMM_SET 2'h3
`define MPCP_RSEL_IRR 2'h2
`define MPCP_RSEL_ISR 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MPCP_RST_BYTE 8'h00
`define MPCP_RST_VBASE 5'h00
`define MPCP_RST_ICW4 8'h00

`endif

// [hw/mpcp_prio.v]
/*
 Fixed-plus-rotating priority pick: finds the highest-priority set bit of an 8-bit vector, level 0 highest before any rotation.
 Assumes the caller supplies the current lowest-priority level.
*/
`timescale 1ns/1ns
module mpcp_prio (
	input wire [7:0] req_i,
	input wire [2:0] lowest_i,
	output reg hit_o,
	output reg [2:0] level_o
);
	integer k;
	reg [2:0] lvl;
	reg found;

	// Walk from just above the lowest level, wrapping round
	always @* begin
		hit_o = 1'b0;
		level_o = 3'h0;
		found = 1'b0;
		lvl = 3'h0;
		for (k = 1; k <= 8; k = k + 1) begin
			lvl = lowest_i + k[2:0];
			if (!found && req_i[lvl]) begin
				found = 1'b1;
				hit_o = 1'b1;
				level_o = lvl;
			end
		end
	end
endmodule

// [hw/mpcp_init_seq.v]
/*
 Initialization-word pointer: steps through the second, third and fourth words after the first, skipping as the first word asks.
 Assumes one-cycle write strobes from the port decoder on the same clock.
*/
`timescale 1ns/1ns
`include "mpcp_defs.vh"
module mpcp_init_seq (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire icw1_wr_i,
	input wire single_i,
	input wire need4_i,
	input wire high_wr_i,
	output wire ptr_icw2_o,
	output wire ptr_icw3_o,
	output wire ptr_icw4_o,
	output wire init_done_o
);
	localparam ST_IDLE = 4'h1;
	localparam ST_ICW2 = 4'h2;
	localparam ST_ICW3 = 4'h4;
	localparam ST_ICW4 = 4'h8;

	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg single_r;
	reg need4_r;

	assign ptr_icw2_o = state_r[1];
	assign ptr_icw3_o = state_r[2];
	assign ptr_icw4_o = state_r[3];
	assign init_done_o = state_r[0];

	// ----------------------------------------
	// Pointer sequence
	// ----------------------------------------
	always @* begin
		state_nxt = state_r;
		if (icw1_wr_i) begin
			state_nxt = ST_ICW2;
		end else if (high_wr_i) begin
			case (state_r)
				ST_ICW2: begin
					if (!single_r)
						state_nxt = ST_ICW3;
					else if (need4_r)
						state_nxt = ST_ICW4;
					else
						state_nxt = ST_IDLE;
				end
				ST_ICW3: begin
					state_nxt = need4_r ? ST_ICW4 : ST_IDLE;
				end
				ST_ICW4: begin
					state_nxt = ST_IDLE;
				end
				default: begin
					state_nxt = state_r;
				end
			endcase
		end
	end

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_IDLE;
			single_r <= 1'b0;
			need4_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (icw1_wr_i) begin
				single_r <= single_i;
				need4_r <= need4_i;
			end
		end
	end
endmodule

// [hw/mpcp_top.v]
/*
 Command-port logic of the master interrupt controller: decodes host writes to the two byte ports, holds the init words,
 mode bits, in-service and mask state, and answers lower/upper port reads.
 Assumes io_* strobes come from logic on ref_clk_i, one cycle per access; irq_i comes from pins and is synchronised here.
*/
// What this block does
// - Bit-4 lower write loads first word, resets sequence
// - Upper writes load pointed word, then advance
// - Single-controller bit skips the cascade word
// - Fourth-word bit clear skips the fourth word
// - Bit 3 picks EOI word or mask/poll word
// - Decode EOI, specific EOI, no-op, set priority
// - Codes 101/111 do EOI plus rotation
// - Codes 100/000 set/clear auto-EOI rotation
// - Bits 2-0 pick the target level
// - Bits 6-5: 10 clears, 11 sets special mask
// - Bit 2 issues a poll command
// - Bits 1-0 choose request or in-service read
// - Vector is base bits above request level
`timescale 1ns/1ns
`include "mpcp_defs.vh"
module mpcp_top (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire io_wr_i,
	input wire io_rd_i,
	input wire [7:0] io_addr_i,
	input wire [7:0] io_wdata_i,
	input wire [7:0] irq_i,
	input wire inta_i,
	output reg [7:0] io_rdata_o,
	output reg io_rvalid_o,
	output reg int_o,
	output reg [7:0] vector_o,
	output reg init_done_o,
	output reg [7:0] icw1_o,
	output reg [7:0] cascade_init_word_o,
	output reg [7:0] init_word_fourth_o,
	output reg special_mask_o,
	output reg rot_aeoi_o
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function [2:0] mpcp_low_kind;
		input [7:0] d;
		begin
			if (d[`MPCP_SEL_ICW1_BIT])
				mpcp_low_kind = 3'h1;
			else if (d[`MPCP_SEL_OCW3_BIT])
				mpcp_low_kind = 3'h4;
			else
				mpcp_low_kind = 3'h2;
		end
	endfunction

	// One-hot mask for a request level
	function [7:0] mpcp_level_bit;
		input [2:0] l;
		begin
			mpcp_level_bit = 8'h01 << l;
		end
	endfunction

	wire low_wr = io_wr_i && (io_addr_i == `MPCP_PORT_LOW);
	wire high_wr = io_wr_i && (io_addr_i == `MPCP_PORT_HIGH);
	wire low_rd = io_rd_i && (io_addr_i == `MPCP_PORT_LOW);
	wire high_rd = io_rd_i && (io_addr_i == `MPCP_PORT_HIGH);
	wire [2:0] kind = mpcp_low_kind(io_wdata_i);
	wire icw1_wr = low_wr && kind[0];
	wire ocw2_wr = low_wr && kind[1];
	wire ocw3_wr = low_wr && kind[2];
	wire [2:0] cmd = io_wdata_i[`MPCP_CMD_HI:`MPCP_CMD_LO];
	wire [2:0] lvl = io_wdata_i[`MPCP_LVL_HI:`MPCP_LVL_LO];
	wire [1:0] smm = io_wdata_i[`MPCP_SMM_HI:`MPCP_SMM_LO];
	wire [1:0] rsel = io_wdata_i[`MPCP_RSEL_HI:`MPCP_RSEL_LO];

	// ----------------------------------------
	// Request input synchroniser
	// ----------------------------------------
	reg [7:0] irq_meta_r;
	reg [7:0] irq_sync_r;
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_meta_r <= `MPCP_RST_BYTE;
			irq_sync_r <= `MPCP_RST_BYTE;
		end else begin
			irq_meta_r <= irq_i;
			irq_sync_r <= irq_meta_r;
		end
	end

	// ----------------------------------------
	// Init pointer
	// ----------------------------------------
	wire ptr2;
	wire ptr3;
	wire ptr4;
	wire seq_done;
	mpcp_init_seq u_seq (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.icw1_wr_i(icw1_wr),
		.single_i(io_wdata_i[`MPCP_SINGLE_CONTROLLER_BIT_BIT]),
		.need4_i(io_wdata_i[`MPCP_IC4_BIT]),
		.high_wr_i(high_wr),
		.ptr_icw2_o(ptr2),
		.ptr_icw3_o(ptr3),
		.ptr_icw4_o(ptr4),
		.init_done_o(seq_done)
	);

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	reg [4:0] vbase_r;
	reg [7:0] mask_r;
	reg [7:0] isr_r;
	reg [7:0] irr_r;
	reg [2:0] lowest_r;
	reg read_isr_r;
	reg poll_pend_r;
	reg inta_d_r;

	// Requests latch until serviced; masked ones do not pend
	wire [7:0] pend = irr_r & ~mask_r;
	// Special mask lets lower levels in while others are in service
	wire [7:0] cand = special_mask_o ? (pend & ~isr_r) : pend;
	wire req_hit;
	wire [2:0] req_lvl;
	wire isr_hit;
	wire [2:0] isr_lvl;
	mpcp_prio u_req_prio (
		.req_i(cand),
		.lowest_i(lowest_r),
		.hit_o(req_hit),
		.level_o(req_lvl)
	);
	mpcp_prio u_isr_prio (
		.req_i(isr_r),
		.lowest_i(lowest_r),
		.hit_o(isr_hit),
		.level_o(isr_lvl)
	);

	// Request outranks highest in-service level unless special mask
	wire [2:0] req_rank = req_lvl - lowest_r - 3'h1;
	wire [2:0] isr_rank = isr_lvl - lowest_r - 3'h1;
	wire may_int = req_hit && (!isr_hit || special_mask_o || (req_rank < isr_rank));

	wire inta_edge = inta_i && !inta_d_r;
	wire ack_now = (inta_edge && may_int) || (low_rd && poll_pend_r && may_int);
	wire aeoi = init_word_fourth_o[1];
	wire ns_eoi = ocw2_wr && ((cmd == `MPCP_CMD_NS_EOI) || (cmd == `MPCP_CMD_ROT_NS_EOI));
	wire sp_eoi = ocw2_wr && ((cmd == `MPCP_CMD_SP_EOI) || (cmd == `MPCP_CMD_ROT_SP_EOI));
	wire [7:0] ack_bit = ack_now ? mpcp_level_bit(req_lvl) : 8'h00;

	reg [7:0] isr_nxt;
	reg [2:0] lowest_nxt;
	always @* begin
		isr_nxt = isr_r;
		lowest_nxt = lowest_r;
		if (ns_eoi && isr_hit) begin
			isr_nxt[isr_lvl] = 1'b0;
			if (cmd == `MPCP_CMD_ROT_NS_EOI)
				lowest_nxt = isr_lvl;
		end
		if (sp_eoi) begin
			isr_nxt[lvl] = 1'b0;
			if (cmd == `MPCP_CMD_ROT_SP_EOI)
				lowest_nxt = lvl;
		end
		if (ocw2_wr && cmd == `MPCP_CMD_SET_PRIO)
			lowest_nxt = lvl;
		if (ack_now) begin
			if (aeoi) begin
				if (rot_aeoi_o)
					lowest_nxt = req_lvl;
			end else begin
				isr_nxt = isr_nxt | mpcp_level_bit(req_lvl);
			end
		end
		if (icw1_wr) begin
			isr_nxt = `MPCP_RST_BYTE;
			lowest_nxt = 3'h7;
		end
	end

	// ----------------------------------------
	// Request, in-service and priority state
	// ----------------------------------------
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			isr_r <= `MPCP_RST_BYTE;
			irr_r <= `MPCP_RST_BYTE;
			lowest_r <= 3'h7;
			inta_d_r <= 1'b0;
		end else begin
			inta_d_r <= inta_i;
			isr_r <= isr_nxt;
			lowest_r <= lowest_nxt;
			// A new request in the acknowledge cycle still latches
			irr_r <= (irr_r & ~ack_bit) | irq_sync_r;
		end
	end

	// ----------------------------------------
	// Init words and interrupt mask
	// ----------------------------------------
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vbase_r <= `MPCP_RST_VBASE;
			mask_r <= `MPCP_RST_BYTE;
			icw1_o <= `MPCP_RST_BYTE;
			cascade_init_word_o <= `MPCP_RST_BYTE;
			init_word_fourth_o <= `MPCP_RST_ICW4;
			init_done_o <= 1'b0;
		end else begin
			init_done_o <= seq_done;
			if (icw1_wr) begin
				icw1_o <= io_wdata_i;
				mask_r <= `MPCP_RST_BYTE;
				// Fourth word defaults when software will not write it
				if (!io_wdata_i[`MPCP_IC4_BIT])
					init_word_fourth_o <= `MPCP_RST_ICW4;
			end
			if (high_wr) begin
				if (ptr2)
					vbase_r <= io_wdata_i[`MPCP_VBASE_HI:`MPCP_VBASE_LO];
				else if (ptr3)
					cascade_init_word_o <= io_wdata_i;
				else if (ptr4)
					init_word_fourth_o <= io_wdata_i;
				else
					mask_r <= io_wdata_i;
			end
		end
	end

	// ----------------------------------------
	// Mode bits and read selection
	// ----------------------------------------
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			special_mask_o <= 1'b0;
			rot_aeoi_o <= 1'b0;
			read_isr_r <= 1'b0;
			poll_pend_r <= 1'b0;
		end else if (icw1_wr) begin
			special_mask_o <= 1'b0;
			rot_aeoi_o <= 1'b0;
			read_isr_r <= 1'b0;
			poll_pend_r <= 1'b0;
		end else begin
			if (ocw2_wr && cmd == `MPCP_CMD_ROT_AEOI_SET)
				rot_aeoi_o <= 1'b1;
			else if (ocw2_wr && cmd == `MPCP_CMD_ROT_AEOI_CLR)
				rot_aeoi_o <= 1'b0;
			if (ocw3_wr) begin
				if (smm == `MPCP_SMM_SET)
					special_mask_o <= 1'b1;
				else if (smm == `MPCP_SMM_CLR)
					special_mask_o <= 1'b0;
				if (rsel == `MPCP_RSEL_IRR)
					read_isr_r <= 1'b0;
				else if (rsel == `MPCP_RSEL_ISR)
					read_isr_r <= 1'b1;
				if (io_wdata_i[`MPCP_POLL_BIT])
					poll_pend_r <= 1'b1;
			end else if (low_rd) begin
				// The lower-port read that follows a poll consumes it
				poll_pend_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Interrupt output and vector
	// ----------------------------------------
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_o <= 1'b0;
			vector_o <= `MPCP_RST_BYTE;
		end else begin
			// Quiet while polling: software chose not to be interrupted
			int_o <= may_int && !poll_pend_r;
			if (ack_now)
				vector_o <= {vbase_r, req_lvl};
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			io_rdata_o <= `MPCP_RST_BYTE;
			io_rvalid_o <= 1'b0;
		end else begin
			io_rvalid_o <= low_rd || high_rd;
			if (low_rd) begin
				if (poll_pend_r)
					io_rdata_o <= {may_int, 4'h0, req_lvl};
				else
					io_rdata_o <= read_isr_r ? isr_r : irr_r;
			end else if (high_rd) begin
				io_rdata_o <= mask_r;
			end
		end
	end
endmodule

// [sim/mpcp_props.sv]
/*
 Checker for the command-port block: decode of lower-port writes and read answers.
 Assumes one clock and active-low async reset; attached by bind to mpcp_top.
*/
`timescale 1ns/1ns
module mpcp_props (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire io_wr_i,
	input wire io_rd_i,
	input wire [7:0] io_addr_i,
	input wire [7:0] io_wdata_i,
	input wire io_rvalid_o,
	input wire init_done_o,
	input wire [7:0] icw1_o,
	input wire special_mask_o,
	input wire rot_aeoi_o
);
	wire rd_ok = io_rd_i && (io_addr_i == 8'h20 || io_addr_i == 8'h21);
	wire wl = io_wr_i && io_addr_i == 8'h20;
	wire w2 = wl && io_wdata_i[4:3] == 2'b00;
	wire w3 = wl && io_wdata_i[4:3] == 2'b01;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_rv; rd_ok |=> io_rvalid_o; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_norv; !rd_ok |=> !io_rvalid_o; endproperty
	a_norv: assert property (p_norv) else $error("answer without read");
	property p_icw1; wl && io_wdata_i[4] |=> icw1_o == $past(io_wdata_i) ##1 !init_done_o; endproperty
	a_icw1: assert property (p_icw1) else $error("first word not taken");
	property p_icw1k; wl && !io_wdata_i[4] |=> $stable(icw1_o); endproperty
	a_icw1k: assert property (p_icw1k) else $error("first word overwritten");
	property p_smms; w3 && io_wdata_i[6:5] == 2'b11 |=> special_mask_o; endproperty
	a_smms: assert property (p_smms) else $error("special mask not set");
	property p_smmc; w3 && io_wdata_i[6:5] == 2'b10 |=> !special_mask_o; endproperty
	a_smmc: assert property (p_smmc) else $error("special mask not cleared");
	property p_smmk; w3 && !io_wdata_i[6] |=> $stable(special_mask_o); endproperty
	a_smmk: assert property (p_smmk) else $error("special mask changed");
	property p_rots; w2 && io_wdata_i[7:5] == 3'h4 |=> rot_aeoi_o; endproperty
	a_rots: assert property (p_rots) else $error("rotate mode not set");
	property p_rotc; w2 && io_wdata_i[7:5] == 3'h0 |=> !rot_aeoi_o; endproperty
	a_rotc: assert property (p_rotc) else $error("rotate mode not cleared");
	property p_rotk; w3 || (w2 && io_wdata_i[6:5] != 2'b00) |=> $stable(rot_aeoi_o); endproperty
	a_rotk: assert property (p_rotk) else $error("rotate mode changed");
	c_rd: cover property (rd_ok ##1 io_rvalid_o);
	c_smm: cover property ($rose(special_mask_o));
	c_rot: cover property ($fell(rot_aeoi_o));
endmodule
bind mpcp_top mpcp_props i_mpcp_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .io_wr_i(io_wr_i),
	.io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rvalid_o(io_rvalid_o),
	.init_done_o(init_done_o), .icw1_o(icw1_o), .special_mask_o(special_mask_o), .rot_aeoi_o(rot_aeoi_o));

// [sim/mpcp_host_model.sv]
/*
 Host processor model: one-cycle port reads and writes.
 Assumes the bench calls xfer; lines change only at the falling edge.
*/
`timescale 1ns/1ns
module mpcp_host_model (
	input wire ref_clk_i,
	output reg io_wr_o,
	output reg io_rd_o,
	output reg [7:0] io_addr_o,
	output reg [7:0] io_wdata_o
);
	initial begin
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_addr_o = 8'h00;
		io_wdata_o = 8'h00;
	end
	task xfer(input w, input [7:0] a, input [7:0] d);
		begin
			@(negedge ref_clk_i);
			io_wr_o = w;
			io_rd_o = !w;
			io_addr_o = a;
			io_wdata_o = (w && a == 8'h20 && d[4:3] == 2'b01) ? {1'b0, d[6:0]} : d;
			@(negedge ref_clk_i);
			io_wr_o = 1'b0;
			io_rd_o = 1'b0;
			// Released lines show inverted values, not stale ones
			io_addr_o = ~a;
			io_wdata_o = ~d;
		end
	endtask
endmodule

// [sim/mpcp_tb_top.sv]
/*
 Self-checking bench for the command port: init sequences, mask, status, poll, EOI and mode words.
 Assumes the host model drives the bus; irq_i and inta_i are driven here.
*/
`timescale 1ns/1ns
module mpcp_tb_top;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg [7:0] irq = 8'h00;
	reg inta = 1'b0;
	wire bus_wr, bus_rd, rv, intr, done, smm, rot;
	wire [7:0] addr, wdata, rdata, vec, icw1, cas, fourth;
	integer num_errors = 0, total_checks = 0, seed = 32'h8BD5, c;
	reg [7:0] vb, m, r, e;
	reg [2:0] l1, l2;
	logic [7:0] exp_q[$];
	always #50 clk = ~clk;
	mpcp_host_model i_mpcp_host_model (.ref_clk_i(clk), .io_wr_o(bus_wr), .io_rd_o(bus_rd), .io_addr_o(addr),
		.io_wdata_o(wdata));
	mpcp_top i_mpcp_top (.ref_clk_i(clk), .rst_n_i(rst_n), .io_wr_i(bus_wr), .io_rd_i(bus_rd), .io_addr_i(addr),
		.io_wdata_i(wdata), .irq_i(irq), .inta_i(inta), .io_rdata_o(rdata), .io_rvalid_o(rv), .int_o(intr),
		.vector_o(vec), .init_done_o(done), .icw1_o(icw1), .cascade_init_word_o(cas),
		.init_word_fourth_o(fourth), .special_mask_o(smm), .rot_aeoi_o(rot));
	function [2:0] low(input [7:0] v);
		integer k;
		begin
			low = 3'h0;
			for (k = 7; k >= 0; k = k - 1) if (v[k]) low = k[2:0];
		end
	endfunction
	task chk(input [7:0] g, input [7:0] x);
		begin
			total_checks = total_checks + 1;
			if (g !== x) begin
				num_errors = num_errors + 1;
				$display("wrong value at %0t: got %h expected %h", $time, g, x);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		i_mpcp_host_model.xfer(1'b1, a, d);
	endtask
	task rd(input [7:0] a, input [7:0] x);
		begin
			exp_q.push_back(x);
			i_mpcp_host_model.xfer(1'b0, a, 8'h00);
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task complete_run;
		begin
			// A read that never answered leaves its note behind
			if (exp_q.size() != 0)
				num_errors = num_errors + 1;
			$display("checks %0d mismatches %0d", total_checks, num_errors);
			if (num_errors == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// Unexpected answer finds the queue empty and compares against X
	always @(negedge clk) if (rv === 1'b1) chk(rdata, exp_q.size() ? exp_q.pop_front() : 8'hXX);
	initial begin
		#(100 * 3000);
		num_errors = num_errors + 1;
		complete_run;
	end
	initial begin
		cyc(8);
		rst_n = 1'b1;
		vb = $random(seed);
		m = $random(seed);
		wr(8'h20, 8'h11);
		chk(icw1, 8'h11);
		cyc(1);
		chk(done, 8'h00);
		wr(8'h21, vb);
		wr(8'h21, m);
		wr(8'h21, 8'h0C);
		cyc(1);
		chk(cas, m);
		chk(fourth, 8'h0C);
		chk(done, 8'h01);
		wr(8'h20, 8'h13);
		wr(8'h21, vb);
		wr(8'h21, 8'h1D);
		cyc(1);
		chk(fourth, 8'h1D);
		wr(8'h20, 8'h12);
		wr(8'h21, vb);
		cyc(1);
		chk(fourth, 8'h00);
		chk(done, 8'h01);
		$display("test 1 done");
		m = $random(seed);
		wr(8'h21, m);
		rd(8'h21, m);
		wr(8'h21, 8'h00);
		$display("test 2 done");
		r = $random(seed) | 8'h90;
		irq = r;
		cyc(4);
		chk(intr, 8'h01);
		l1 = low(r);
		l2 = low(r & ~(8'h01 << l1));
		wr(8'h20, 8'h0A);
		rd(8'h20, r);
		// Drop the top request so that its acknowledge leaves it serviced
		irq = r & ~(8'h01 << l1);
		wr(8'h20, 8'h0C);
		cyc(1);
		chk(intr, 8'h00);
		rd(8'h20, {5'h10, l1});
		wr(8'h20, 8'h0B);
		rd(8'h20, 8'h01 << l1);
		wr(8'h20, {5'h0C, l1});
		rd(8'h20, 8'h00);
		inta = 1'b1;
		cyc(3);
		chk(vec, {vb[7:3], l2});
		inta = 1'b0;
		rd(8'h20, 8'h01 << l2);
		wr(8'h20, 8'h20);
		rd(8'h20, 8'h00);
		$display("test 3 done");
		for (c = 7; c >= 0; c = c - 1) begin
			wr(8'h20, {c[2:0], 5'h07});
			e = (c > 0 && c < 5);
			chk(rot, e);
		end
		$display("test 4 done");
		for (c = 0; c < 4; c = c + 1) begin
			wr(8'h20, {1'b0, ~c[0], ~c[1], 5'h08});
			chk(smm, c < 2);
		end
		$display("test 5 done");
		i_mpcp_host_model.xfer(1'b0, 8'h22, 8'h00);
		wr(8'h22, 8'h13);
		cyc(1);
		chk(icw1, 8'h12);
		$display("test 6 done");
		complete_run;
	end
endmodule
